/* File: hw/nvm_pkg.sv */
// Constants shared by the byte store and its write requester.
// Assumes a single 10 MHz system clock and synchronous reset.
`default_nettype none
package nvm_pkg;
	localparam int BYTES = 2048;
	localparam int ROWS = 128;
	localparam int ROW_BYTES = 16;
	localparam int ADDR_W = 11;
	localparam int ROW_W = 7;
	localparam int COL_W = 4;
	localparam logic [7:0] ERASED_VALUE = 8'h00;
	localparam int CLK_HZ = 10000000;
	localparam int WRITE_TIME_MS = 20;
	localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

/* File: hw/nvm_if.sv */
// Link between the store's command port and the requester.
// Assumes both ends share sys_clk.
`default_nettype none
interface nvm_if;
	logic cmd_valid;
	logic [nvm_pkg::ROW_W-1:0] cmd_row;
	logic [nvm_pkg::COL_W-1:0] cmd_col;
	logic [7:0] cmd_data;
	logic cmd_ready;
	logic busy;
	logic done;
	modport store (input cmd_valid, input cmd_row, input cmd_col, input cmd_data,
		output cmd_ready, output busy, output done);
	modport requester (output cmd_valid, output cmd_row, output cmd_col,
		output cmd_data, input cmd_ready, input busy, input done);
endinterface
`default_nettype wire

/* File: hw/nvm_store.sv */
// Byte store with direct read port and row-write command port.
// Assumes the requester loads a row buffer, then commits it.
//
// Summary of operation
// - 2 KB store, each byte addressable
// - Direct single-byte reads, any order
// - Contents change only via write commands
// - Reads stay served while writing
// - Erase and program whole rows only
// - 128 rows of 16 bytes
// - All bytes read zero initially
// - Data space only, no fetch path
// - No error correction on bytes
// - A write lasts up to 20 ms
// - System avoids reset during writes
`default_nettype none
module nvm_store #(
	parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic [nvm_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_valid,
	nvm_if.store link
);
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		ERASE = 3'b010,
		PROGRAM = 3'b100
	} state_t;

	////////////////////////////////////////////////////////////////
	// Control, address split and staging
	state_t state;
	logic [31:0] timer;
	logic [nvm_pkg::ROW_W-1:0] row_sel;

	logic [nvm_pkg::ROW_W-1:0] rd_row;
	logic [nvm_pkg::COL_W-1:0] rd_col;
	logic [7:0] bank_rd [nvm_pkg::ROW_BYTES];

	logic take_byte;
	logic last_col;
	logic commit;
	logic phase_end;
	logic erase_strobe;
	logic program_strobe;

	// Byte address splits into row and byte within row
	assign rd_row = rd_addr[nvm_pkg::ADDR_W-1:nvm_pkg::COL_W];
	assign rd_col = rd_addr[nvm_pkg::COL_W-1:0];

	// Bytes are taken only while idle, which includes the last cycle that busy stays high
	assign take_byte = link.cmd_valid && (state == IDLE);
	assign last_col =
		link.cmd_col == nvm_pkg::COL_W'(nvm_pkg::ROW_BYTES - 1);
	// A row without its last byte never commits
	assign commit = take_byte && last_col;

	assign phase_end = timer <= 32'h1;
	assign erase_strobe = (state == ERASE) && phase_end;
	assign program_strobe = (state == PROGRAM) && phase_end;
	// Reset mid-write abandons the row; the system must avoid it

	////////////////////////////////////////////////////////////////
	// Sequencer: erase first, then program the staged row
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= IDLE;
		end else begin
			unique case (state)
				IDLE: begin
					if (commit) begin
						state <= ERASE;
					end
				end
				ERASE: begin
					if (phase_end) begin
						state <= PROGRAM;
					end
				end
				PROGRAM: begin
					if (phase_end) begin
						state <= IDLE;
					end
				end
			endcase
		end
	end

	// Each phase counts its half of the write time in system clocks
	// One down counter serves both phases, at the cost of 32 bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer <= 32'h0;
		end else begin
			unique case (state)
				IDLE: begin
					if (commit) begin
						timer <= 32'(WRITE_CYCLES / 2);
					end
				end
				ERASE: begin
					if (phase_end) begin
						timer <= 32'(WRITE_CYCLES - WRITE_CYCLES / 2);
					end else begin
						timer <= timer - 32'h1;
					end
				end
				PROGRAM: begin
					if (!phase_end) begin
						timer <= timer - 32'h1;
					end
				end
			endcase
		end
	end

	// Row held from commit to the end of program
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			row_sel <= '0;
		end else if (commit) begin
			row_sel <= link.cmd_row;
		end
	end

	////////////////////////////////////////////////////////////////
	// One bank per byte column; a row write hits all banks at once
	generate
		for (genvar b = 0; b < nvm_pkg::ROW_BYTES; b++) begin : g_col
			// Plain bytes, no check bits; rows across sixteen banks
			// Factory value only; reset leaves nonvolatile bytes alone
			logic [7:0] bank [nvm_pkg::ROWS] = '{default: nvm_pkg::ERASED_VALUE};
			logic [7:0] held;

			// Byte staged for this column until the row commits
			always_ff @(posedge sys_clk) begin
				if (take_byte && link.cmd_col == nvm_pkg::COL_W'(b)) begin
					held <= link.cmd_data;
				end
			end

			// Only the command path writes a bank
			always_ff @(posedge sys_clk) begin
				if (!rst && erase_strobe) begin
					bank[row_sel] <= nvm_pkg::ERASED_VALUE;
				end else if (!rst && program_strobe) begin
					bank[row_sel] <= held;
				end
			end

			// Read tap for this column
			assign bank_rd[b] = bank[rd_row];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Data read port only; no fetch port exists
	// Reads never look at the sequencer, so they go on during writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
		end
	end

	// Data holds until the next read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= bank_rd[rd_col];
		end
	end

	////////////////////////////////////////////////////////////////
	// Busy includes the commit edge so no second row slips
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.busy <= 1'b0;
		end else begin
			link.busy <= (state != IDLE) || commit;
		end
	end

	// Ready is the complement of busy except in reset, where both are low; both registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.cmd_ready <= 1'b0;
		end else begin
			link.cmd_ready <= (state == IDLE) && !commit;
		end
	end

	// One pulse at the end of program
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.done <= 1'b0;
		end else begin
			link.done <= program_strobe;
		end
	end
endmodule
`default_nettype wire

/* File: hw/nvm_requester.sv */
// Requester end: turns a user row-write request into 16 commands.
// Assumes the user holds data stable via row_data until accepted.
`default_nettype none
module nvm_requester (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_start,
	input wire logic [nvm_pkg::ROW_W-1:0] wr_row,
	input wire logic [8*nvm_pkg::ROW_BYTES-1:0] row_data,
	output logic wr_busy,
	output logic wr_done,
	nvm_if.requester link
);
	logic [nvm_pkg::COL_W-1:0] col;
	logic sending;
	logic waiting;
	logic [nvm_pkg::ROW_W-1:0] row;
	logic [8*nvm_pkg::ROW_BYTES-1:0] data;

	////////////////////////////////////////////////////////////////
	// Only path to change contents is this command stream
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sending <= 1'b0;
			waiting <= 1'b0;
			col <= '0;
			row <= '0;
			data <= '0;
			link.cmd_valid <= 1'b0;
			link.cmd_row <= '0;
			link.cmd_col <= '0;
			link.cmd_data <= 8'h00;
			wr_busy <= 1'b0;
			wr_done <= 1'b0;
		end else begin
			wr_done <= 1'b0;
			link.cmd_valid <= 1'b0;
			if (!sending && !waiting && wr_start && link.cmd_ready) begin
				sending <= 1'b1;
				wr_busy <= 1'b1;
				col <= '0;
				row <= wr_row;
				data <= row_data;
			end else if (sending) begin
				link.cmd_valid <= 1'b1;
				link.cmd_row <= row;
				link.cmd_col <= col;
				link.cmd_data <= data[8*col +: 8];
				col <= col + nvm_pkg::COL_W'(1);
				if (col == nvm_pkg::COL_W'(nvm_pkg::ROW_BYTES - 1)) begin
					sending <= 1'b0;
					waiting <= 1'b1;
				end
			end else if (waiting && link.done) begin
				// Reset must not arrive before this point
				waiting <= 1'b0;
				wr_busy <= 1'b0;
				wr_done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/nvm_link_monitor.sv */
// Checker for the row-write link between requester and store.
// Assumes instantiation beside the shared interface, one clock.
`default_nettype none
module nvm_link_monitor #(
	parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic [nvm_pkg::ROW_W-1:0] cmd_row,
	input wire logic [nvm_pkg::COL_W-1:0] cmd_col,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic busy,
	input wire logic done
);
localparam int LO = WRITE_CYCLES - 2;
localparam int HI = WRITE_CYCLES + 4;
// Counter, not a delay range: the real write time is far too long to unroll
logic [31:0] busy_len;
always_ff @(posedge sys_clk) begin
	if (rst) begin
		busy_len <= 32'h0;
	end else if (busy) begin
		busy_len <= busy_len + 32'h1;
	end else begin
		busy_len <= 32'h0;
	end
end
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////
property p_idle_send; cmd_valid |-> !busy; endproperty
a_idle_send: assert property (p_idle_send) else $error("byte sent while busy");
property p_ready_idle; cmd_ready |-> !busy; endproperty
a_ready_idle: assert property (p_ready_idle) else $error("ready while busy");
property p_commit; cmd_valid && cmd_col == 4'hf |-> ##[1:2] busy; endproperty
a_commit: assert property (p_commit) else $error("last byte did not start write");
property p_done_once; done |=> !done; endproperty
a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
property p_length; done |-> busy_len >= 32'(LO) && busy_len <= 32'(WRITE_CYCLES); endproperty
a_length: assert property (p_length) else $error("write length wrong");
property p_no_hang; busy |-> busy_len <= 32'(HI); endproperty
a_no_hang: assert property (p_no_hang) else $error("write never ended");
property p_end; $fell(busy) |-> done || $past(done); endproperty
a_end: assert property (p_end) else $error("busy fell without done");
// Whole row sent in one run, columns ascending
property p_col_step;
	cmd_valid && cmd_col != 4'hf |=> cmd_valid && cmd_col == $past(cmd_col) + 4'h1;
endproperty
a_col_step: assert property (p_col_step) else $error("column sequence broken");
property p_row_hold; cmd_valid && cmd_col != 4'hf |=> $stable(cmd_row); endproperty
a_row_hold: assert property (p_row_hold) else $error("row changed mid load");
c_write: cover property ($rose(busy));
c_done: cover property (done);
c_last: cover property (cmd_valid && cmd_col == 4'hf);
endmodule
`default_nettype wire

/* File: test/byte_eeprom_access_test.sv */
// Bench joining store and requester, with a byte-array model.
// Assumes both design ends and the link interface are compiled.
`default_nettype none
module byte_eeprom_access_test;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk = 0, rst = 1, rd_en = 0, wr_start = 0, rd_valid, wr_busy, wr_done;
logic [10:0] rd_addr = 0;
logic [7:0] rd_data;
logic [6:0] wr_row = 0, r;
logic [127:0] row_data = 0;
logic [7:0] m [2048];
int err_total = 0, cmp_count = 0, i;
int unsigned s = 32'h11a1e;
nvm_if lk();
nvm_store #(.WRITE_CYCLES(20)) i_nvm_store(.sys_clk, .rst, .rd_en, .rd_addr,
	.rd_data, .rd_valid, .link(lk));
nvm_requester i_nvm_requester(.sys_clk, .rst, .wr_start, .wr_row, .row_data,
	.wr_busy, .wr_done, .link(lk));
nvm_link_monitor #(.WRITE_CYCLES(20)) i_nvm_link_monitor(.sys_clk, .rst,
	.cmd_valid(lk.cmd_valid), .cmd_row(lk.cmd_row), .cmd_col(lk.cmd_col),
	.cmd_data(lk.cmd_data), .cmd_ready(lk.cmd_ready), .busy(lk.busy), .done(lk.done));
always #50 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////
function int unsigned nx();
	s = s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	return s;
endfunction
task chk(string n, logic [7:0] a, logic [7:0] e);
	cmp_count++;
	if (a !== e) begin
		err_total++;
		$display("Error %s expected %h seen %h", n, e, a);
	end
endtask
// Leaves rd_en high after the read; every call sets it again
task rd(logic [10:0] a);
	rd_en = 1;
	rd_addr = a;
	@(negedge sys_clk);
	chk("rd_valid", rd_valid, 8'h01);
	chk("rd_data", rd_data, m[a]);
endtask
task give_verdict();
	$display("checks %0d errors %0d", cmp_count, err_total);
	if (err_total == 0 && cmp_count > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
	foreach (m[k]) m[k] = 8'h00;
	repeat (4) @(negedge sys_clk);
	rst = 0;
	@(negedge sys_clk);
	for (int a = 0; a < 2048; a += 97) rd(11'(a));
	for (int j = 0; j < 3; j++) begin
		r = j == 0 ? 7'h00 : j == 1 ? 7'h7f : 7'(nx());
		rd_en = 0;
		wr_row = r;
		for (int k = 0; k < 16; k++) row_data[8*k+:8] = 8'(nx());
		wr_start = 1;
		@(negedge sys_clk);
		wr_start = 0;
		for (int k = 0; k < 16; k++) m[{r, 4'(k)}] = row_data[8*k+:8];
		@(negedge sys_clk);
		chk("wr_busy", wr_busy, 8'h01);
		// Second start while busy must be ignored
		wr_row = r ^ 7'h01;
		wr_start = 1;
		@(negedge sys_clk);
		wr_start = 0;
		rd({r ^ 7'h40, 4'h3});
		rd_en = 0;
		i = 0;
		while (wr_done !== 1'b1 && i < 100) begin
			@(negedge sys_clk);
			i++;
		end
		chk("wr_done", wr_done, 8'h01);
		chk("wr_busy", wr_busy, 8'h00);
		for (int k = 0; k < 16; k++) rd({r, 4'(k)});
		rd({r ^ 7'h01, 4'h0});
	end
	// Reset only between writes, never while one runs
	rd_en = 0;
	rst = 1;
	repeat (2) @(negedge sys_clk);
	rst = 0;
	chk("wr_busy", wr_busy, 8'h00);
	chk("rd_valid", rd_valid, 8'h00);
	@(negedge sys_clk);
	for (int k = 0; k < 16; k++) rd({r, 4'(k)});
	for (int k = 0; k < 20; k++) rd(11'(nx()));
	give_verdict();
end
initial begin
	#200000;
	err_total++;
	give_verdict();
end
endmodule
`default_nettype wire
